// ### adaptive_clock_divider_control.sv
// Contract
// - The second channel output divides by its 4-bit code plus one.
// - The first channel output divides by its bits 7:4 code plus one.
// - The master clock input divides by its 3-bit code plus one.
// - Reserved bits read zero, and every divider field resets to zero.
//
// Register access over AXI4-Lite is this design's own decision.
`default_nettype none

module divider_unit #(
  parameter int W = 4
) (
  // Clock and reset.
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Source clock level and requested code.
  input  wire logic         clk_level,
  input  wire logic [W-1:0] code,
  // Divided clock and the code in force.
  output logic              div_clk,
  output logic [W-1:0]      active_code
);

  logic         prev_ff;
  logic         out_ff;
  logic [W-1:0] cnt_ff;
  logic [W-1:0] code_ff;
  logic         nxt_prev;
  logic         nxt_out;
  logic [W-1:0] nxt_cnt;
  logic [W-1:0] nxt_code;
  logic         rise;
  logic         wrap;

  assign rise        = clk_level & ~prev_ff;
  assign wrap        = (cnt_ff == code_ff);
  assign div_clk     = out_ff;
  assign active_code = code_ff;

  // Counts source rising edges and takes a new code only on wrap.
  always_comb begin
    nxt_prev = clk_level;
    nxt_cnt  = cnt_ff;
    nxt_code = code_ff;
    nxt_out  = out_ff;
    if (rise) begin
      if (wrap) begin
        nxt_cnt  = '0;
        nxt_code = code;
      end else begin
        nxt_cnt = cnt_ff + 1'b1;
      end
      // High for the first half of the period, the longer half when odd.
      nxt_out = (nxt_cnt <= (nxt_code >> 1));
    end
    // Divide by one passes the source level through a flip-flop.
    if (nxt_code == '0) begin
      nxt_out = clk_level;
    end
  end

  // Divider state registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_ff <= clk_level; // Seeded so release shows no false edge.
      out_ff  <= 1'b0;
      cnt_ff  <= '0;
      code_ff <= '0;
    end else begin
      prev_ff <= nxt_prev;
      out_ff  <= nxt_out;
      cnt_ff  <= nxt_cnt;
      code_ff <= nxt_code;
    end
  end

  // The count never passes the code in force.
  property p_cnt_in_range;
    @(posedge aclk) disable iff (!aresetn)
    cnt_ff <= code_ff;
  endproperty
  a_cnt_in_range: assert property (p_cnt_in_range)
    else $error("divider count beyond its code");

  // A code change lands only on a fresh period.
  property p_load_boundary;
    @(posedge aclk) disable iff (!aresetn)
    (code_ff != $past(code_ff)) |-> (cnt_ff == '0) && $past(rise);
  endproperty
  a_load_boundary: assert property (p_load_boundary)
    else $error("divider code changed off a boundary");

  // A wrap in a dividing mode starts the high phase.
  property p_wrap_high;
    @(posedge aclk) disable iff (!aresetn)
    (rise && wrap) |=> div_clk;
  endproperty
  a_wrap_high: assert property (p_wrap_high)
    else $error("divided clock not high after wrap");

endmodule

module adaptive_clock_divider_control (
  // Clock and reset.
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  // Write address channel.
  input  wire logic [adaptive_clk_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  // Write data channel.
  input  wire logic [adaptive_clk_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  // Write response channel.
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  // Read address channel.
  input  wire logic [adaptive_clk_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  // Read data channel.
  output logic [adaptive_clk_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  // Source clocks, sampled as levels.
  input  wire logic                                first_synth_channel_clk,
  input  wire logic                                second_synth_channel_clk,
  input  wire logic                                master_clock_input,
  // Divided clocks and generator control.
  output logic                                     first_synth_channel_div_clk,
  output logic                                     second_synth_channel_div_clk,
  output logic                                     master_clock_input_div_clk,
  output logic [adaptive_clk_pkg::REG_W-1:0]       clock_generator_control
);

  localparam int DW = adaptive_clk_pkg::DATA_W;
  localparam int RW = adaptive_clk_pkg::REG_W;
  localparam int IW = adaptive_clk_pkg::IDX_W;
  localparam int AW = adaptive_clk_pkg::ADDR_W;
  localparam int LW = adaptive_clk_pkg::LSB_W;

  // Register file and channel state.
  logic                       aw_got_ff;
  logic                       w_got_ff;
  logic [IW-1:0]              aw_idx_ff;
  logic [RW-1:0]              w_data_ff;
  logic                       w_strb_ff;
  logic                       bvalid_ff;
  logic [1:0]                 bresp_ff;
  logic                       rvalid_ff;
  logic [1:0]                 rresp_ff;
  logic [DW-1:0]              rdata_ff;
  logic [RW-1:0]              gen_ctl_ff;
  adaptive_clk_pkg::ch1_div_s ch1_ff;
  adaptive_clk_pkg::ch2_div_s ch2_ff;

  logic                       nxt_aw_got;
  logic                       nxt_w_got;
  logic [IW-1:0]              nxt_aw_idx;
  logic [RW-1:0]              nxt_w_data;
  logic                       nxt_w_strb;
  logic                       nxt_bvalid;
  logic [1:0]                 nxt_bresp;
  logic                       nxt_rvalid;
  logic [1:0]                 nxt_rresp;
  logic [DW-1:0]              nxt_rdata;
  logic [RW-1:0]              nxt_gen_ctl;
  adaptive_clk_pkg::ch1_div_s nxt_ch1;
  adaptive_clk_pkg::ch2_div_s nxt_ch2;

  logic                       wr_do;
  logic                       wr_hit;
  logic [IW-1:0]              ar_idx;
  logic [DW-1:0]              rd_word;
  logic                       rd_hit;
  adaptive_clk_pkg::status_s  status;
  logic [adaptive_clk_pkg::OUT_CODE_W-1:0] ch1_active;
  logic [adaptive_clk_pkg::OUT_CODE_W-1:0] ch2_active;
  logic [adaptive_clk_pkg::IN_CODE_W-1:0]  in_active;

  // Handshake outputs; one write and one read are held at a time.
  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready  = !w_got_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;
  assign clock_generator_control = gen_ctl_ff;

  assign wr_do  = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_hit = (aw_idx_ff == adaptive_clk_pkg::IDX_GEN_CTL) ||
                  (aw_idx_ff == adaptive_clk_pkg::IDX_CH1_DIV) ||
                  (aw_idx_ff == adaptive_clk_pkg::IDX_CH2_DIV) ||
                  (aw_idx_ff == adaptive_clk_pkg::IDX_STATUS);
  assign ar_idx = s_axi_araddr[AW-1:LW];

  // Status shows the codes each divider has actually taken.
  always_comb begin
    status            = '0;
    status.ch1_active = ch1_active;
    status.ch2_active = ch2_active;
    status.in_active  = in_active;
  end

  // Read decode; reserved bits and upper bits always read zero.
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    unique case (ar_idx)
      adaptive_clk_pkg::IDX_GEN_CTL: begin
        rd_word[RW-1:0] = gen_ctl_ff & adaptive_clk_pkg::GEN_CTL_RW_MASK;
      end
      adaptive_clk_pkg::IDX_CH1_DIV: begin
        rd_word[RW-1:0] = {ch1_ff.output_divide_code, 1'b0,
                           ch1_ff.input_divide_code};
      end
      adaptive_clk_pkg::IDX_CH2_DIV: begin
        rd_word[RW-1:0] = {ch2_ff.output_divide_code,
                           {adaptive_clk_pkg::OUT_CODE_W{1'b0}}};
      end
      adaptive_clk_pkg::IDX_STATUS: begin
        rd_word = status;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Next state for both bus channels and the registers.
  always_comb begin
    nxt_aw_got  = aw_got_ff;
    nxt_w_got   = w_got_ff;
    nxt_aw_idx  = aw_idx_ff;
    nxt_w_data  = w_data_ff;
    nxt_w_strb  = w_strb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rresp   = rresp_ff;
    nxt_rdata   = rdata_ff;
    nxt_gen_ctl = gen_ctl_ff;
    nxt_ch1     = ch1_ff;
    nxt_ch2     = ch2_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_got = 1'b1;
      nxt_aw_idx = s_axi_awaddr[AW-1:LW];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_got  = 1'b1;
      nxt_w_data = s_axi_wdata[RW-1:0];
      nxt_w_strb = s_axi_wstrb[0];
    end
    if (wr_do) begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = wr_hit ? adaptive_clk_pkg::RESP_OKAY
                          : adaptive_clk_pkg::RESP_SLVERR;
      if (w_strb_ff) begin
        unique case (aw_idx_ff)
          adaptive_clk_pkg::IDX_GEN_CTL: begin
            nxt_gen_ctl = w_data_ff & adaptive_clk_pkg::GEN_CTL_RW_MASK;
          end
          adaptive_clk_pkg::IDX_CH1_DIV: begin
            nxt_ch1      = adaptive_clk_pkg::ch1_div_s'(w_data_ff);
            nxt_ch1.resv = 1'b0;
          end
          adaptive_clk_pkg::IDX_CH2_DIV: begin
            nxt_ch2      = adaptive_clk_pkg::ch2_div_s'(w_data_ff);
            nxt_ch2.resv = '0;
          end
          default: begin
          end
        endcase
      end
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = rd_word;
      nxt_rresp  = rd_hit ? adaptive_clk_pkg::RESP_OKAY
                          : adaptive_clk_pkg::RESP_SLVERR;
    end
  end

  // Bus and register flip-flops; every divider field clears to divide by one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      aw_idx_ff  <= '0;
      w_data_ff  <= '0;
      w_strb_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= adaptive_clk_pkg::RESP_OKAY;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= adaptive_clk_pkg::RESP_OKAY;
      rdata_ff   <= '0;
      gen_ctl_ff <= adaptive_clk_pkg::GEN_CTL_RST;
      ch1_ff     <= adaptive_clk_pkg::CH1_DIV_RST;
      ch2_ff     <= adaptive_clk_pkg::CH2_DIV_RST;
    end else begin
      aw_got_ff  <= nxt_aw_got;
      w_got_ff   <= nxt_w_got;
      aw_idx_ff  <= nxt_aw_idx;
      w_data_ff  <= nxt_w_data;
      w_strb_ff  <= nxt_w_strb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      rvalid_ff  <= nxt_rvalid;
      rresp_ff   <= nxt_rresp;
      rdata_ff   <= nxt_rdata;
      gen_ctl_ff <= nxt_gen_ctl;
      ch1_ff     <= nxt_ch1;
      ch2_ff     <= nxt_ch2;
    end
  end

  // Second channel output divider.
  divider_unit #(.W(adaptive_clk_pkg::OUT_CODE_W)) u_ch2_out (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .clk_level   (second_synth_channel_clk),
    .code        (ch2_ff.output_divide_code),
    .div_clk     (second_synth_channel_div_clk),
    .active_code (ch2_active)
  );

  // First channel output divider.
  divider_unit #(.W(adaptive_clk_pkg::OUT_CODE_W)) u_ch1_out (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .clk_level   (first_synth_channel_clk),
    .code        (ch1_ff.output_divide_code),
    .div_clk     (first_synth_channel_div_clk),
    .active_code (ch1_active)
  );

  // Master clock input divider for the first channel.
  divider_unit #(.W(adaptive_clk_pkg::IN_CODE_W)) u_ch1_in (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .clk_level   (master_clock_input),
    .code        (ch1_ff.input_divide_code),
    .div_clk     (master_clock_input_div_clk),
    .active_code (in_active)
  );

  // Applied codes only ever move to the programmed codes.
  property p_ch2_apply;
    @(posedge aclk) disable iff (!aresetn)
    (ch2_active != $past(ch2_active)) |->
      (ch2_active == $past(ch2_ff.output_divide_code));
  endproperty
  a_ch2_apply: assert property (p_ch2_apply)
    else $error("second channel applied a code not programmed");

  property p_ch1_apply;
    @(posedge aclk) disable iff (!aresetn)
    (ch1_active != $past(ch1_active)) |->
      (ch1_active == $past(ch1_ff.output_divide_code));
  endproperty
  a_ch1_apply: assert property (p_ch1_apply)
    else $error("first channel applied a code not programmed");

  property p_in_apply;
    @(posedge aclk) disable iff (!aresetn)
    (in_active != $past(in_active)) |->
      (in_active == $past(ch1_ff.input_divide_code));
  endproperty
  a_in_apply: assert property (p_in_apply)
    else $error("input divider applied a code not programmed");

  // A read of the second channel register never shows reserved bits.
  property p_ch2_resv_read;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready &&
     ar_idx == adaptive_clk_pkg::IDX_CH2_DIV) |=>
      s_axi_rvalid &&
      (s_axi_rdata == DW'({$past(ch2_ff.output_divide_code),
                           {adaptive_clk_pkg::OUT_CODE_W{1'b0}}}));
  endproperty
  a_ch2_resv_read: assert property (p_ch2_resv_read)
    else $error("second channel read shows reserved bits");

  // Reset leaves every divider field at divide by one.
  property p_reset_zero;
    @(posedge aclk)
    !aresetn |=> (ch1_ff == '0) && (ch2_ff == '0) && !s_axi_bvalid;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("divider fields not cleared by reset");

  // Covers for the main scenarios.
  c_ch2_max: cover property (@(posedge aclk) disable iff (!aresetn)
    ch2_active == '1);
  c_in_max: cover property (@(posedge aclk) disable iff (!aresetn)
    in_active == '1);
  c_bad_read: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rresp == adaptive_clk_pkg::RESP_SLVERR);

endmodule
`default_nettype wire

// ### adaptive_clk_pkg.sv
`default_nettype none
package adaptive_clk_pkg;

  // Bus geometry.
  localparam int DATA_W = 32;
  localparam int ADDR_W = 18;
  localparam int IDX_W  = 16;
  localparam int REG_W  = 8;
  localparam int LSB_W  = 2;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_GEN_CTL = 16'hffe1;
  localparam logic [IDX_W-1:0] IDX_CH1_DIV = 16'hffe2;
  localparam logic [IDX_W-1:0] IDX_CH2_DIV = 16'hfff6;
  localparam logic [IDX_W-1:0] IDX_STATUS  = 16'hffd0;

  // Field widths.
  localparam int OUT_CODE_W = 4;
  localparam int IN_CODE_W  = 3;

  // Reset values and read masks.
  localparam logic [REG_W-1:0] GEN_CTL_RST     = 8'h00;
  localparam logic [REG_W-1:0] GEN_CTL_RW_MASK = 8'hdf;

  // Response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // First channel divider register layout.
  typedef struct packed {
    logic [OUT_CODE_W-1:0] output_divide_code;
    logic                  resv;
    logic [IN_CODE_W-1:0]  input_divide_code;
  } ch1_div_s;

  // Second channel divider register layout.
  typedef struct packed {
    logic [OUT_CODE_W-1:0] output_divide_code;
    logic [OUT_CODE_W-1:0] resv;
  } ch2_div_s;

  // Status word showing the codes now applied by the dividers.
  typedef struct packed {
    logic [DATA_W-IN_CODE_W-2*OUT_CODE_W-1:0] zero;
    logic [IN_CODE_W-1:0]                     in_active;
    logic [OUT_CODE_W-1:0]                    ch2_active;
    logic [OUT_CODE_W-1:0]                    ch1_active;
  } status_s;

  localparam ch1_div_s CH1_DIV_RST = '0;
  localparam ch2_div_s CH2_DIV_RST = '0;

endpackage
`default_nettype wire

// ### tb_adaptive_clock_divider_control.sv
`default_nettype none
module tb_adaptive_clock_divider_control;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int AW = adaptive_clk_pkg::ADDR_W;
  localparam logic [AW-1:0] A_GEN = {adaptive_clk_pkg::IDX_GEN_CTL, 2'h0};
  localparam logic [AW-1:0] A_CH1 = {adaptive_clk_pkg::IDX_CH1_DIV, 2'h0};
  localparam logic [AW-1:0] A_CH2 = {adaptive_clk_pkg::IDX_CH2_DIV, 2'h0};
  localparam logic [AW-1:0] A_STS = {adaptive_clk_pkg::IDX_STATUS, 2'h0};
  localparam logic [AW-1:0] A_BAD = 18'h00010;
  localparam logic [1:0]    OK    = adaptive_clk_pkg::RESP_OKAY;

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  mismatches++; $display("FAIL %s expected %h seen %h", nm, e, g); end end

  // Bus, source clock and divided clock signals.
  logic          aclk = 1'b0, aresetn = 1'b0;
  logic [AW-1:0] awaddr = '0, araddr = '0;
  logic [31:0]   wdata = '0, rdata;
  logic [3:0]    wstrb = '0;
  logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic          arvalid = 1'b0, rready = 1'b0;
  logic          awready, wready, bvalid, arready, rvalid;
  logic [1:0]    bresp, rresp;
  logic          src = 1'b0;
  logic [1:0]    src_cnt = 2'h0;
  logic          c1_div, c2_div, m_div;
  logic [7:0]    gen_ctl;
  logic [2:0]    dclk, prev = 3'h0;
  int            mismatches = 0, n_compared = 0, run [3];
  int            hi, per, code;

  assign dclk = {m_div, c2_div, c1_div};

  adaptive_clock_divider_control adaptive_clock_divider_control_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .first_synth_channel_clk(src), .second_synth_channel_clk(~src),
    .master_clock_input(src),
    .first_synth_channel_div_clk(c1_div),
    .second_synth_channel_div_clk(c2_div),
    .master_clock_input_div_clk(m_div), .clock_generator_control(gen_ctl)
  );

  // Clock at 25 MHz; the source clocks run at a quarter of that rate.
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    src_cnt <= src_cnt + 2'h1;
    if (src_cnt[0]) src <= ~src;
  end

  // Every phase of a divided clock lasts at least one source half period.
  always @(negedge aclk) begin
    for (int i = 0; i < 3; i++) begin
      if (!aresetn) begin
        run[i] = 2;
      end else if (dclk[i] !== prev[i]) begin
        `CHK("min_phase", 1'b1, (run[i] >= 2))
        run[i] = 1;
      end else begin
        run[i]++;
      end
    end
    prev = dclk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Gives up on a wait that ran out of cycles.
  task automatic timeout(input int k);
    if (k >= 400) begin
      mismatches++;
      $display("FAIL wait expected done seen timeout");
      print_verdict();
    end
  endtask

  // One write; address and data are released as each is taken.
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic ap, wp, ta, tw, got;
    int   k;
    ap = 1'b1; wp = 1'b1; got = 1'b0; k = 0;
    // Starts just after a rising edge, one edge after any earlier call.
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while ((ap || wp || !got) && k < 400) begin
      @(negedge aclk);
      ta = ap && awready;
      tw = wp && wready;
      got = !ap && !wp && bvalid;
      if (got) `CHK("bresp", er, bresp)
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (got) bready <= 1'b0;
      ap = ap && !ta; wp = wp && !tw; k++;
    end
    timeout(k);
  endtask

  // One read compared against the expected word and response.
  task automatic chk_read(input logic [AW-1:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
    logic ap, got;
    int   k;
    ap = 1'b1; got = 1'b0; k = 0;
    // Starts just after a rising edge, one edge after any earlier call.
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!got && k < 400) begin
      @(negedge aclk);
      got = !ap && rvalid;
      if (got) `CHK("rdata", ed, rdata)
      if (got) `CHK("rresp", er, rresp)
      if (ap && arready) ap = 1'b0;
      @(posedge aclk);
      if (!ap) arvalid <= 1'b0;
      if (got) rready <= 1'b0;
      k++;
    end
    timeout(k);
  endtask

  // Waits until one divided clock shows the given level.
  task automatic wait_level(input int s, input logic v, inout int n);
    int k;
    k = 0;
    while (dclk[s] !== v && k < 400) begin
      @(negedge aclk);
      k++;
      n++;
    end
    timeout(k);
  endtask

  // Skips three periods, then measures the high phase and the period.
  task automatic measure(input int s, output int h, output int p);
    int n;
    n = 0;
    repeat (3) begin
      wait_level(s, 1'b0, n);
      wait_level(s, 1'b1, n);
    end
    n = 0;
    wait_level(s, 1'b0, n);
    h = n;
    wait_level(s, 1'b1, n);
    p = n;
  endtask

  // Main sequence: reset values, field access, ratios, reset in mid-run.
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_read(A_CH1, 32'h0, OK);
    chk_read(A_CH2, 32'h0, OK);
    wr(A_STS, 32'hffffffff, 4'hf, OK);
    chk_read(A_STS, 32'h0, OK);
    wr(A_CH1, 32'hffffffff, 4'hf, OK);
    chk_read(A_CH1, 32'h000000f7, OK);
    wr(A_CH2, 32'hffffffff, 4'hf, OK);
    chk_read(A_CH2, 32'h000000f0, OK);
    // With byte lane zero off the register must keep its value.
    wr(A_CH2, 32'h00000000, 4'he, OK);
    chk_read(A_CH2, 32'h000000f0, OK);
    wr(A_GEN, 32'hffffffff, 4'hf, OK);
    chk_read(A_GEN, 32'h000000df, OK);
    `CHK("gen_ctl", 8'hdf, gen_ctl)
    wr(A_BAD, 32'h000000ff, 4'hf, adaptive_clk_pkg::RESP_SLVERR);
    chk_read(A_BAD, 32'h0, adaptive_clk_pkg::RESP_SLVERR);
    for (int s = 0; s < 3; s++) begin
      for (int j = 0; j < 3; j++) begin
        code = (j == 0) ? 0 : (j == 1) ? 1 : (s == 2) ? 7 : 15;
        wr((s == 1) ? A_CH2 : A_CH1, (s == 2) ? code : code << 4, 4'hf, OK);
        measure(s, hi, per);
        `CHK("period", (code + 1) * 4, per)
        `CHK("high", (code == 0) ? 2 : (code / 2 + 1) * 4, hi)
      end
    end
    chk_read(A_STS, 32'h000007f0, OK);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_read(A_CH1, 32'h0, OK);
    chk_read(A_CH2, 32'h0, OK);
    chk_read(A_STS, 32'h0, OK);
    `CHK("gen_ctl", 8'h00, gen_ctl)
    print_verdict();
  end
endmodule
`default_nettype wire
